// *** rtl/scw_device_end.sv ***
`timescale 1ns/10ps
`default_nettype none
// Contract
// - status reports 24 candidate delay positions
// - status bit one means marginal position
// - bits 0 and 23 always marginal
// - select index picks sampling delay tap
// - only taps 0 to 15 selectable
// - zoom zero coarse steps, one fine
// - controller normally sets fine steps
// - controller picks middle safe position
// - controller may store select, reprogram
// - deterministic edge captures reference every time
// - sync pin used only in 8b10b
// - 64b66b lanes carry sync headers
// - eight lanes wide, four single channel
// - device clock drives all logic
// - 8b10b output stays receiver compatible
module scw_device_end #(
  parameter bit SINGLE_CHANNEL = 1'b0
) (
  // device clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // link side
  scw_link_if.device link,
  // configuration
  input wire logic [scw_pkg::SELECT_WIDTH-1:0] capture_delay_select,
  input wire logic fine_step_enable,
  input wire scw_pkg::scw_enc_type encoding_mode,
  input wire logic [7:0] lmfc_period,
  // status register reads
  input wire logic [7:0] reg_address,
  output logic [7:0] reg_read_data,
  // sample payload
  input wire logic [scw_pkg::LANES_WIDE*8-1:0] payload
);
  typedef enum logic [1:0] {
    SCW_LINK_IDLE = 2'b00,
    SCW_LINK_CGS = 2'b01,
    SCW_LINK_DATA = 2'b10
  } scw_link_state_type;

  typedef struct packed {
    // handshake pipe and reference edge memory
    logic [2:0] sync_pipe;
    logic ref_prev;
    // multiframe counter and its restart pulse
    logic [7:0] lmfc_count;
    logic lmfc_edge;
    // link start-up and lane contents
    scw_link_state_type link_state;
    logic [scw_pkg::LANES_WIDE*8-1:0] data;
    logic [scw_pkg::LANES_WIDE*2-1:0] header;
    logic [7:0] read_data;
  } scw_dev_state_type;
  scw_dev_state_type state_reg;
  scw_dev_state_type state_next;

  // status byte behind a register offset, zero elsewhere
  function automatic logic [7:0] status_byte(input logic [scw_pkg::STATUS_WIDTH-1:0] st,
                                             input logic [7:0] address);
    // low byte holds the smallest delays
    case (address)
      scw_pkg::STATUS_LOW_OFFSET: status_byte = st[7:0];
      scw_pkg::STATUS_MID_OFFSET: status_byte = st[15:8];
      scw_pkg::STATUS_HIGH_OFFSET: status_byte = st[23:16];
      default: status_byte = 8'h00;
    endcase
  endfunction

  // byte mask that blanks lanes the variant does not have
  function automatic logic [scw_pkg::LANES_WIDE*8-1:0] lane_mask(
    input logic [scw_pkg::LANES_WIDE-1:0] on
  );
    lane_mask = '0;
    // one byte of payload per lane
    for (int l = 0; l < scw_pkg::LANES_WIDE; l++) begin
      lane_mask[l*8 +: 8] = {8{on[l]}};
    end
  endfunction

  // true in the block-coded mode, where the sync pin is not used
  function automatic logic is_block_mode(input scw_pkg::scw_enc_type mode);
    is_block_mode = (mode == scw_pkg::SCW_ENC_64B66B);
  endfunction

  // one step of the link start-up sequence
  function automatic scw_link_state_type link_step(input scw_link_state_type now,
                                                   input logic block_mode,
                                                   input logic pin_low,
                                                   input logic frame_edge);
    link_step = now;
    case (now)
      SCW_LINK_IDLE: begin
        // block mode needs no handshake, byte mode waits for the pin
        if (block_mode) begin
          link_step = SCW_LINK_DATA;
        end else if (pin_low) begin
          link_step = SCW_LINK_CGS;
        end
      end
      SCW_LINK_CGS: begin
        // code groups until the pin is released and a frame boundary comes
        if (block_mode) begin
          link_step = SCW_LINK_DATA;
        end else if (!pin_low && frame_edge) begin
          link_step = SCW_LINK_DATA;
        end
      end
      SCW_LINK_DATA: begin
        // a new request in byte mode restarts code groups
        if (!block_mode && pin_low) begin
          link_step = SCW_LINK_CGS;
        end
      end
      default: begin
        link_step = SCW_LINK_IDLE;
      end
    endcase
  endfunction

  logic [scw_pkg::STATUS_WIDTH-1:0] status;
  logic captured;
  logic sync_low;
  logic [scw_pkg::LANES_WIDE-1:0] lanes_on;

  // delay line and position detector
  scw_window_detect detect (
    .clk_sys(clk_sys),
    .reset(reset),
    .samples(link.sysref_samples),
    .fine_step_enable(fine_step_enable),
    .capture_delay_select(capture_delay_select),
    .capture_window_status(status),
    .captured_level(captured)
  );

  // lane count per variant
  assign lanes_on = SINGLE_CHANNEL ? 8'h0f : 8'hff;
  // synchronised handshake, second and third stage agree
  assign sync_low = !state_reg.sync_pipe[1] && !state_reg.sync_pipe[2];

  always_comb begin
    state_next = state_reg;

    // handshake pin shifted through three stages
    state_next.sync_pipe = {state_reg.sync_pipe[1:0], link.sync_request_pin_n};
    state_next.ref_prev = captured;
    state_next.lmfc_edge = 1'b0;
    // captured rising reference restarts the counter
    if (captured && !state_reg.ref_prev) begin
      state_next.lmfc_count = 8'h00;
      state_next.lmfc_edge = 1'b1;
    end else if (state_reg.lmfc_count >= lmfc_period) begin
      state_next.lmfc_count = 8'h00;
      state_next.lmfc_edge = 1'b1;
    end else begin
      state_next.lmfc_count = state_reg.lmfc_count + 8'h01;
    end

    // link start: pin only in 8b10b, headers only in 64b66b
    state_next.link_state = link_step(state_reg.link_state, is_block_mode(encoding_mode),
                                      sync_low, state_next.lmfc_edge);

    // lane payload
    if (state_next.link_state == SCW_LINK_CGS) begin
      state_next.data = {scw_pkg::LANES_WIDE{scw_pkg::K28_5_CODE}};
    end else if (state_next.link_state == SCW_LINK_DATA) begin
      state_next.data = payload;
    end else begin
      state_next.data = '0;
    end

    // sync headers per lane in the block-coded mode
    if (is_block_mode(encoding_mode)) begin
      state_next.header = {scw_pkg::LANES_WIDE{scw_pkg::SYNC_HEADER_DATA}};
    end else begin
      state_next.header = '0;
    end

    // status byte reads, others read zero
    // registered one cycle after the address
    state_next.read_data = status_byte(status, reg_address);
  end

  // state register
  // pin pipe resets to the released level, so no false request follows reset
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      state_reg <= '{sync_pipe: 3'h7, link_state: SCW_LINK_IDLE, default: '0};
    end else begin
      state_reg <= state_next;
    end
  end

  // lane outputs, absent lanes' data held at zero, their sync headers not masked
  assign link.lane_data = state_reg.data & lane_mask(lanes_on);
  assign link.lane_header = state_reg.header;
  assign link.lane_enable = lanes_on;
  assign link.lmfc_align = state_reg.lmfc_edge;
  assign reg_read_data = state_reg.read_data;
endmodule // scw_device_end
`default_nettype wire

// *** rtl/scw_pkg.sv ***
package scw_pkg;
  // position status layout
  localparam int unsigned STATUS_WIDTH = 24;
  localparam int unsigned SELECT_WIDTH = 4;
  localparam int unsigned SELECTABLE_MAX = 15;
  localparam int unsigned LOW_EDGE_POS = 0;
  localparam int unsigned HIGH_EDGE_POS = 23;
  // register offsets of the status bytes
  localparam logic [7:0] STATUS_LOW_OFFSET = 8'h2c;
  localparam logic [7:0] STATUS_MID_OFFSET = 8'h2d;
  localparam logic [7:0] STATUS_HIGH_OFFSET = 8'h2e;
  // delay line: coarse and fine step per tap, in fast-sample units
  localparam int unsigned TAP_COUNT = 24;
  localparam int unsigned COARSE_STEP = 2;
  localparam int unsigned FINE_STEP = 1;
  localparam int unsigned LINE_DEPTH = 48;
  // multiframe / extended multiblock counter length in device clocks
  localparam logic [7:0] LMFC_PERIOD_RESET = 8'h1f;
  // lane counts
  localparam int unsigned LANES_WIDE = 8;
  localparam int unsigned LANES_NARROW = 4;
  // encoding modes
  typedef enum logic [0:0] {
    SCW_ENC_8B10B = 1'b0,
    SCW_ENC_64B66B = 1'b1
  } scw_enc_type;
  localparam logic [1:0] SYNC_HEADER_DATA = 2'h1;
  localparam logic [7:0] K28_5_CODE = 8'hbc;
endpackage

// *** rtl/scw_link_if.sv ***
`timescale 1ns/10ps
`default_nettype none
interface scw_link_if;
  // timing reference as seen by the device, oversampled per clk_sys
  logic [scw_pkg::LINE_DEPTH-1:0] sysref_samples;
  // receiver handshake, active low
  logic sync_request_pin_n;
  // serial lane payload and per-lane sync header
  logic [scw_pkg::LANES_WIDE*8-1:0] lane_data;
  logic [scw_pkg::LANES_WIDE*2-1:0] lane_header;
  logic [scw_pkg::LANES_WIDE-1:0] lane_enable;
  logic lmfc_align;
  modport device (
    input sysref_samples,
    input sync_request_pin_n,
    output lane_data,
    output lane_header,
    output lane_enable,
    output lmfc_align
  );
  modport partner (
    output sysref_samples,
    output sync_request_pin_n,
    input lane_data,
    input lane_header,
    input lane_enable,
    input lmfc_align
  );
endinterface
`default_nettype wire

// *** rtl/scw_window_detect.sv ***
`timescale 1ns/10ps
`default_nettype none
module scw_window_detect (
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // oversampled reference, oldest sample in bit 0
  input wire logic [scw_pkg::LINE_DEPTH-1:0] samples,
  input wire logic fine_step_enable,
  input wire logic [scw_pkg::SELECT_WIDTH-1:0] capture_delay_select,
  // results
  output logic [scw_pkg::STATUS_WIDTH-1:0] capture_window_status,
  output logic captured_level
);
  typedef struct packed {
    logic [scw_pkg::STATUS_WIDTH-1:0] status;
    logic captured;
  } scw_det_state_type;
  scw_det_state_type state_reg;
  scw_det_state_type state_next;

  // sample index of a tap under the chosen step size
  function automatic int unsigned tap_index(input int unsigned tap, input logic fine);
    tap_index = fine ? tap * scw_pkg::FINE_STEP : tap * scw_pkg::COARSE_STEP;
  endfunction

  // marginal where a tap and its neighbour disagree; edges always marginal
  always_comb begin
    state_next = state_reg;
    for (int unsigned t = 0; t < scw_pkg::TAP_COUNT; t++) begin
      if (t == scw_pkg::LOW_EDGE_POS || t == scw_pkg::HIGH_EDGE_POS) begin
        state_next.status[t] = 1'b1;
      end else begin
        state_next.status[t] = samples[tap_index(t, fine_step_enable)] ^
                               samples[tap_index(t + 1, fine_step_enable)];
      end
    end
    // capture at the selected tap only, 0..15 reachable
    state_next.captured = samples[tap_index(32'(capture_delay_select), fine_step_enable)];
  end

  // state register
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign capture_window_status = state_reg.status;
  assign captured_level = state_reg.captured;
endmodule // scw_window_detect
`default_nettype wire

// *** rtl/scw_partner_end.sv ***
`timescale 1ns/10ps
`default_nettype none
module scw_partner_end (
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // link side
  scw_link_if.partner link,
  // user side
  input wire logic [scw_pkg::LINE_DEPTH-1:0] reference_samples,
  input wire logic encoding_is_64b66b,
  input wire logic request_resync,
  input wire logic [scw_pkg::STATUS_WIDTH-1:0] status_in,
  output logic [scw_pkg::SELECT_WIDTH-1:0] chosen_select,
  output logic [scw_pkg::LANES_WIDE*8-1:0] received_data,
  output logic aligned
);
  typedef struct packed {
    logic sync_n;
    logic [scw_pkg::SELECT_WIDTH-1:0] select;
    logic [scw_pkg::LANES_WIDE*8-1:0] data;
    logic aligned;
  } scw_prt_state_type;
  scw_prt_state_type state_reg;
  scw_prt_state_type state_next;

  // middle of the first safe run among taps 0..15
  function automatic logic [3:0] pick_middle(input logic [23:0] st);
    int first;
    int last;
    first = -1;
    last = -1;
    for (int i = 0; i <= 15; i++) begin
      if (!st[i] && first < 0) first = i;
      if (!st[i] && first >= 0 && last == i - 1) last = i;
      if (!st[i] && first >= 0 && last < 0) last = i;
    end
    if (first < 0) pick_middle = 4'h0;
    else pick_middle = 4'((first + last) / 2);
  endfunction

  always_comb begin
    state_next = state_reg;
    state_next.select = pick_middle(status_in);
    // request only in 8b10b, held low while request_resync is high
    state_next.sync_n = encoding_is_64b66b ? 1'b1 : !request_resync;
    state_next.data = link.lane_data;
    state_next.aligned = link.lmfc_align;
  end

  // state register
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      state_reg <= '{sync_n: 1'b1, default: '0};
    end else begin
      state_reg <= state_next;
    end
  end

  assign link.sysref_samples = reference_samples;
  assign link.sync_request_pin_n = state_reg.sync_n;
  assign chosen_select = state_reg.select;
  assign received_data = state_reg.data;
  assign aligned = state_reg.aligned;
endmodule // scw_partner_end
`default_nettype wire

// *** dv/scw_link_props.sv ***
`timescale 1ns/10ps
`default_nettype none
module scw_link_props (
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // link signals
  input wire logic [scw_pkg::LINE_DEPTH-1:0] sysref_samples,
  input wire logic sync_request_pin_n,
  input wire logic [scw_pkg::LANES_WIDE*8-1:0] lane_data,
  input wire logic [scw_pkg::LANES_WIDE*2-1:0] lane_header,
  input wire logic [scw_pkg::LANES_WIDE-1:0] lane_enable,
  input wire logic lmfc_align
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);
  // lane count fixed by variant
  a_enable_value: assert property (lane_enable == 8'hff || lane_enable == 8'h0f)
    else $error("lane enable width wrong");
  a_enable_steady: assert property ($stable(lane_enable))
    else $error("lane enable changed");
  a_upper_masked: assert property (lane_enable == 8'h0f |-> lane_data[63:32] == 32'h0)
    else $error("masked lanes carry data");
  // sync headers only 00 or 01, same on lanes 0 to 3
  a_header_form: assert property ((lane_header & 16'haaaa) == 16'h0)
    else $error("bad sync header");
  a_header_uniform: assert property (lane_header[7:0] inside {8'h00, 8'h55})
    else $error("headers differ");
  // held pin in 8b10b gives code group fill
  a_cgs_fill: assert property ((!sync_request_pin_n && lane_header == 16'h0)[*6]
    |-> lane_data[7:0] == scw_pkg::K28_5_CODE) else $error("no fill during pin low");
  // reference rise restarts the counter two clocks later
  a_align_rise: assert property ($past(sysref_samples) == '0 && &sysref_samples
    |-> ##2 lmfc_align) else $error("align pulse missing");
  a_align_single: assert property ($past(sysref_samples) == '0 && &sysref_samples
    |-> ##3 !lmfc_align) else $error("align pulse too long");
  // main scenarios
  c_align: cover property (lmfc_align);
  c_cgs: cover property (lane_header == 16'h0 && lane_data[7:0] == scw_pkg::K28_5_CODE);
  c_blocks: cover property (lane_header == 16'h5555);
endmodule // scw_link_props
`default_nettype wire

// *** dv/sysref_capture_window_tb.sv ***
`timescale 1ns/10ps
`default_nettype none
module sysref_capture_window_tb;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic [3:0] sel = 4'h0;
  logic zoom = 1'b1;
  scw_pkg::scw_enc_type mode = scw_pkg::SCW_ENC_8B10B;
  logic [7:0] addr = 8'h00;
  logic [7:0] rdata;
  logic [63:0] payload = 64'h0;
  logic [47:0] ref_s = 48'h0;
  logic resync = 1'b0;
  logic [23:0] status_in = 24'h0;
  logic [3:0] chosen;
  logic [63:0] rx_data;
  logic aligned;
  int fail_count = 0;
  int checks_done = 0;
  // both ends across one link
  scw_link_if link ();
  scw_device_end scw_device_end_i (.clk_sys(clk_sys), .reset(reset), .link(link.device),
    .capture_delay_select(sel), .fine_step_enable(zoom), .encoding_mode(mode),
    .lmfc_period(scw_pkg::LMFC_PERIOD_RESET), .reg_address(addr), .reg_read_data(rdata),
    .payload(payload));
  scw_partner_end scw_partner_end_i (.clk_sys(clk_sys), .reset(reset), .link(link.partner),
    .reference_samples(ref_s), .encoding_is_64b66b(mode == scw_pkg::SCW_ENC_64B66B),
    .request_resync(resync), .status_in(status_in), .chosen_select(chosen),
    .received_data(rx_data), .aligned(aligned));
  scw_link_props scw_link_props_i (.clk_sys(clk_sys), .reset(reset),
    .sysref_samples(link.sysref_samples), .sync_request_pin_n(link.sync_request_pin_n),
    .lane_data(link.lane_data), .lane_header(link.lane_header),
    .lane_enable(link.lane_enable), .lmfc_align(link.lmfc_align));
  // 20 MHz clock
  always #25 clk_sys = ~clk_sys;
  // shared helpers
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #2;
  endtask
  task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %s exp %h seen %h", what, exp, seen);
    end
  endtask
  function automatic logic [23:0] exp_status(input logic [47:0] s, input logic fine);
    int st;
    st = fine ? scw_pkg::FINE_STEP : scw_pkg::COARSE_STEP;
    exp_status = 24'h0;
    for (int t = 1; t < 23; t++) exp_status[t] = s[t*st] ^ s[(t+1)*st];
    exp_status[0] = 1'b1;
    exp_status[23] = 1'b1;
  endfunction
  task automatic read_status(output logic [23:0] v);
    for (int b = 0; b < 3; b++) begin
      addr = scw_pkg::STATUS_LOW_OFFSET + 8'(b);
      tick(1);
      v[b*8 +: 8] = rdata;
    end
  endtask
  task automatic wait_data();
    int n = 0;
    while (link.lane_data !== payload && n < 80) begin
      tick(1);
      n++;
    end
    check("lanes", link.lane_data, payload);
    tick(3);
    check("rx", rx_data, payload);
  endtask
  // status map for both step sizes and three edge spots
  task automatic t_window();
    int pos[3] = '{5, 20, 33};
    logic [23:0] v;
    for (int z = 0; z < 2; z++) begin
      foreach (pos[i]) begin
        zoom = z[0];
        ref_s = {48{1'b1}} << pos[i];
        tick(4);
        read_status(v);
        check("status", 64'(v), 64'(exp_status(ref_s, zoom)));
        if (pos[i] == 5) check("status5", 64'(v), z ? 64'h800011 : 64'h800005);
        status_in = v;
        tick(2);
        if (pos[i] == 5) check("pick", 64'(chosen), z ? 64'h2 : 64'h1);
      end
    end
    addr = 8'h2f;
    tick(1);
    check("unmapped", 64'(rdata), 64'h0);
  endtask
  // selected tap decides whether the counter restarts
  task automatic t_select();
    logic [3:0] s[3] = '{4'h3, 4'hf, 4'h6};
    logic z[3] = '{1'b1, 1'b1, 1'b0};
    logic hit[3] = '{1'b0, 1'b1, 1'b1};
    logic seen;
    logic seen_rx;
    for (int i = 0; i < 3; i++) begin
      sel = s[i];
      zoom = z[i];
      ref_s = '0;
      tick(3);
      ref_s = '1;
      tick(3);
      ref_s = '0;
      tick(3);
      ref_s = {48{1'b1}} << 10;
      seen = 1'b0;
      seen_rx = 1'b0;
      repeat (5) begin
        tick(1);
        seen |= link.lmfc_align;
        seen_rx |= aligned;
      end
      check("align", 64'(seen), 64'(hit[i]));
      check("aligned", 64'(seen_rx), 64'(hit[i]));
    end
  endtask
  // 8b10b handshake then data
  task automatic t_link8();
    mode = scw_pkg::SCW_ENC_8B10B;
    payload = 64'h0123456789abcdef;
    resync = 1'b1;
    tick(8);
    check("pin", 64'(link.sync_request_pin_n), 64'h0);
    check("cgs", 64'(link.lane_data[7:0]), 64'(scw_pkg::K28_5_CODE));
    check("hdr8", 64'(link.lane_header), 64'h0);
    resync = 1'b0;
    wait_data();
  endtask
  // 64b66b keeps the pin released despite a resync request
  task automatic t_link64();
    mode = scw_pkg::SCW_ENC_64B66B;
    payload = 64'hfedcba9876543210;
    resync = 1'b1;
    tick(3);
    wait_data();
    check("hdr64", 64'(link.lane_header), 64'h5555);
    check("lanes on", 64'(link.lane_enable), 64'hff);
    check("pin64", 64'(link.sync_request_pin_n), 64'h1);
    resync = 1'b0;
  endtask
  task automatic print_verdict();
    $display("checks %0d fails %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // main sequence
  initial begin
    tick(10);
    reset = 1'b0;
    tick(2);
    t_window();
    t_select();
    t_link8();
    t_link64();
    print_verdict();
  end
  // watchdog
  initial begin
    repeat (3000) @(posedge clk_sys);
    fail_count++;
    print_verdict();
  end
endmodule // sysref_capture_window_tb
`default_nettype wire
